// ===== swc_sleep_wakeup_control.sv
// power-down entry and wake-up controller with apb registers
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - reset pin wake gives full device reset
// - watchdog or interrupt wake resumes, no reset
// - watchdog wakes only when enabled
// - wake sources: irq pin, pin change, peripherals
// - powerdown flag set at power-up, cleared by sleep
// - timeout flag cleared on watchdog wake
// - next instruction prefetched before sleep completes
// - enabled source wakes regardless of global enable
// - global enable clear: continue, no vectoring
// - global enable set: run prefetched, then vector
// - pending enabled flag wakes immediately after sleep
// - watchdog cleared on every wake
// - sleep entry: clear watchdog, clear PD, set TO
// - oscillator stopped, pins held during sleep
// - watchdog resets when running, wakes when asleep
module swc_sleep_wakeup_control #(
    parameter int unsigned WDT_LIMIT = swc_pkg::WDT_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    input wire logic ext_reset_pin_n,
    input wire logic ext_irq_pin,
    input wire logic [swc_pkg::PIN_W-1:0] gpio_pins,
    // peripheral interrupt flags
    input wire logic [swc_pkg::PERIPH_W-1:0] periph_irq_flags,
    // core handshake
    input wire swc_pkg::swc_core_req_t core_req,
    output swc_pkg::swc_core_ctl_t core_ctl,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // whole state of the block
    typedef struct packed {
        swc_pkg::swc_state_t st;
        swc_pkg::swc_ctrl_t ctrl;
        swc_pkg::swc_evt_t evt;
        swc_pkg::swc_evt_t mask;
        logic powerdown_flag_n;
        logic timeout_flag_n;
        logic ext_flag;
        logic pc_flag;
        logic irq_pin_d;
        logic [swc_pkg::PIN_W-1:0] pins_d;
        logic hist_ok;
        logic woke_irq;
        logic wdt_clear;
        swc_pkg::swc_core_ctl_t core;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swc_regs_t;

    localparam swc_regs_t REGS_RESET = '{st: swc_pkg::SWC_RUN, ctrl: swc_pkg::CTRL_RESET,
        evt: swc_pkg::EVT_RESET, mask: swc_pkg::MASK_RESET, powerdown_flag_n: 1'b1,
        timeout_flag_n: 1'b1, ext_flag: 1'b0, pc_flag: 1'b0, irq_pin_d: 1'b0, pins_d: '0,
        hist_ok: 1'b0, woke_irq: 1'b0, wdt_clear: 1'b0, core: swc_pkg::CORE_CTL_RESET,
        irq: 1'b0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};

    swc_regs_t r;
    swc_regs_t next_r;

    // synchronised pins
    logic [swc_pkg::SYNC_W-1:0] sync_q;
    logic ext_rst_s;
    logic ext_irq_s;
    logic [swc_pkg::PIN_W-1:0] pins_s;

    // watchdog status
    logic [swc_pkg::WDT_CNT_W-1:0] watchdog_counter;
    logic wdt_to;

    // combined wake request
    logic wake_req;

    ////////////////////////////////////////////////////////////////////////
    // address decode used by response and write paths
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == swc_pkg::ADDR_CTRL) || (a == swc_pkg::ADDR_FLAGS) ||
            (a == swc_pkg::ADDR_EVT) || (a == swc_pkg::ADDR_MASK);
    endfunction

    // read data for one address
    function automatic logic [31:0] read_word(input swc_regs_t s, input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            swc_pkg::ADDR_CTRL: w[4:0] = s.ctrl;
            swc_pkg::ADDR_FLAGS: begin
                w[swc_pkg::FLG_PD] = s.powerdown_flag_n;
                w[swc_pkg::FLG_TO] = s.timeout_flag_n;
                w[swc_pkg::FLG_ASLEEP] = (s.st == swc_pkg::SWC_ASLEEP);
                w[swc_pkg::FLG_EXT] = s.ext_flag;
                w[swc_pkg::FLG_PC] = s.pc_flag;
            end
            swc_pkg::ADDR_EVT: w[3:0] = s.evt;
            swc_pkg::ADDR_MASK: w[3:0] = s.mask;
            default: w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins cross into the clock domain; reset pin inverted so reset state is idle
    swc_sync #(
        .W(swc_pkg::SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({~ext_reset_pin_n, ext_irq_pin, gpio_pins}),
        .q(sync_q)
    );

    assign ext_rst_s = sync_q[swc_pkg::SYNC_W-1];
    assign ext_irq_s = sync_q[swc_pkg::SYNC_W-2];
    assign pins_s = sync_q[swc_pkg::PIN_W-1:0];

    // watchdog counts only while enabled
    swc_watchdog #(
        .LIMIT(WDT_LIMIT)
    ) u_wdt (
        .pclk(pclk),
        .presetn(presetn),
        .enable(r.ctrl.wdt_en),
        .clear(r.wdt_clear),
        .watchdog_counter(watchdog_counter),
        .timeout(wdt_to)
    );

    // any enabled flag requests a wake, global enable ignored
    assign wake_req = (r.ctrl.en_ext && r.ext_flag) || (r.ctrl.en_pinchg && r.pc_flag) ||
        (r.ctrl.en_periph && (|periph_irq_flags));

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic setup;
        logic wr;
        logic ext_edge;
        logic pc_edge;
        logic ext_clr;
        logic pc_clr;
        logic enter_sleep;
        logic leave_sleep;
        logic [3:0] evt_clr;
        swc_pkg::swc_evt_t evt_set;
        setup = psel && !penable;
        wr = psel && penable && r.pready && pwrite && addr_hit(paddr);
        ext_edge = r.hist_ok && ext_irq_s && !r.irq_pin_d;
        pc_edge = r.hist_ok && (pins_s != r.pins_d);
        ext_clr = 1'b0;
        pc_clr = 1'b0;
        enter_sleep = 1'b0;
        leave_sleep = 1'b0;
        evt_clr = 4'h0;
        evt_set = '0;
        next_r = r;
        // pulses default low
        next_r.core.resume = 1'b0;
        next_r.core.vector_req = 1'b0;
        next_r.core.dev_reset = 1'b0;
        next_r.wdt_clear = 1'b0;
        // apb answer one cycle after setup
        next_r.pready = setup;
        next_r.pslverr = setup && !addr_hit(paddr);
        next_r.prdata = setup ? read_word(r, paddr) : 32'h0000_0000;
        // register writes at the completing edge
        if (wr) begin
            case (paddr)
                swc_pkg::ADDR_CTRL: next_r.ctrl = pwdata[4:0];
                swc_pkg::ADDR_FLAGS: begin
                    ext_clr = pwdata[swc_pkg::FLG_EXT];
                    pc_clr = pwdata[swc_pkg::FLG_PC];
                end
                swc_pkg::ADDR_EVT: evt_clr = pwdata[3:0];
                swc_pkg::ADDR_MASK: next_r.mask = pwdata[3:0];
                default: next_r.mask = r.mask;
            endcase
        end
        // pin history for edge and change detection
        next_r.irq_pin_d = ext_irq_s;
        next_r.pins_d = pins_s;
        next_r.hist_ok = 1'b1;
        // reset pin wins over everything
        if (ext_rst_s) begin
            next_r.core.dev_reset = 1'b1;
            next_r.st = swc_pkg::SWC_RUN;
            next_r.woke_irq = 1'b0;
            if (r.st == swc_pkg::SWC_ASLEEP) begin
                evt_set.ext_reset_wake = 1'b1;
                leave_sleep = 1'b1;
            end
        end else if (wdt_to && r.st != swc_pkg::SWC_ASLEEP) begin
            // watchdog time-out while running resets the device
            next_r.core.dev_reset = 1'b1;
            next_r.timeout_flag_n = 1'b0;
            next_r.st = swc_pkg::SWC_RUN;
            next_r.woke_irq = 1'b0;
            evt_set.wdt_reset = 1'b1;
        end else begin
            unique case (r.st)
                // normal execution
                swc_pkg::SWC_RUN: begin
                    if (core_req.clrwdt_exec) begin
                        next_r.wdt_clear = 1'b1;
                        next_r.powerdown_flag_n = 1'b1;
                        next_r.timeout_flag_n = 1'b1;
                    end else if (core_req.sleep_exec) begin
                        if (core_req.prefetch_valid) begin
                            enter_sleep = 1'b1;
                        end else begin
                            next_r.st = swc_pkg::SWC_FETCH_WAIT;
                        end
                    end
                end
                // sleep waits for the prefetch of the next word
                swc_pkg::SWC_FETCH_WAIT: begin
                    if (core_req.prefetch_valid) begin
                        enter_sleep = 1'b1;
                    end
                end
                // powered down
                swc_pkg::SWC_ASLEEP: begin
                    if (wdt_to) begin
                        next_r.timeout_flag_n = 1'b0;
                        evt_set.wdt_wake = 1'b1;
                        next_r.woke_irq = 1'b0;
                        leave_sleep = 1'b1;
                    end else if (wake_req) begin
                        evt_set.irq_wake = 1'b1;
                        next_r.woke_irq = 1'b1;
                        leave_sleep = 1'b1;
                    end
                    if (leave_sleep) begin
                        next_r.st = swc_pkg::SWC_WAKE_EXEC;
                        next_r.core.resume = 1'b1;
                    end
                end
                // prefetched word runs, then vector if enabled
                swc_pkg::SWC_WAKE_EXEC: begin
                    next_r.core.vector_req = r.woke_irq && r.ctrl.global_irq_enable;
                    next_r.woke_irq = 1'b0;
                    next_r.st = swc_pkg::SWC_RUN;
                end
            endcase
        end
        // sleep entry housekeeping
        if (enter_sleep) begin
            next_r.st = swc_pkg::SWC_ASLEEP;
            next_r.powerdown_flag_n = 1'b0;
            next_r.timeout_flag_n = 1'b1;
            next_r.wdt_clear = 1'b1;
            next_r.core.halt = 1'b1;
            next_r.core.osc_enable = 1'b0;
            next_r.core.io_hold = 1'b1;
        end
        // any exit from sleep
        if (leave_sleep) begin
            next_r.wdt_clear = 1'b1;
            next_r.core.halt = 1'b0;
            next_r.core.osc_enable = 1'b1;
            next_r.core.io_hold = 1'b0;
        end
        // sticky flags: set wins over clear
        next_r.ext_flag = (r.ext_flag && !ext_clr) || ext_edge;
        next_r.pc_flag = (r.pc_flag && !pc_clr) || pc_edge;
        next_r.evt = (r.evt & ~evt_clr) | evt_set;
        next_r.irq = |(next_r.evt & next_r.mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign core_ctl = r.core;
    assign irq = r.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_EXT_RESET_WAKE: assert property (
        r.st == swc_pkg::SWC_ASLEEP && ext_rst_s |=> core_ctl.dev_reset && !core_ctl.halt)
        else $error("reset pin wake did not reset");
    AST_WAKE_NO_RESET: assert property (
        r.st == swc_pkg::SWC_ASLEEP && !ext_rst_s && (wdt_to || wake_req)
        |=> core_ctl.resume && !core_ctl.dev_reset ##1 r.st == swc_pkg::SWC_RUN)
        else $error("wake did not resume");
    AST_WDT_NEEDS_EN: assert property (
        wdt_to |-> $past(r.ctrl.wdt_en))
        else $error("watchdog fired while disabled");
    AST_PERIPH_WAKE: assert property (
        r.st == swc_pkg::SWC_ASLEEP && !ext_rst_s && r.ctrl.en_periph && (|periph_irq_flags)
        |=> core_ctl.resume)
        else $error("peripheral flag did not wake");
    AST_SLEEP_FLAGS: assert property (
        $rose(core_ctl.halt) |-> !r.powerdown_flag_n && r.timeout_flag_n && !core_ctl.osc_enable)
        else $error("flags wrong on sleep entry");
    AST_TO_ON_WDT_WAKE: assert property (
        r.st == swc_pkg::SWC_ASLEEP && wdt_to && !ext_rst_s |=> !r.timeout_flag_n && core_ctl.resume)
        else $error("timeout flag not cleared on watchdog wake");
    AST_PREFETCH_FIRST: assert property (
        $rose(core_ctl.halt) |-> $past(core_req.prefetch_valid))
        else $error("sleep entered without prefetch");
    AST_GIE_IGNORED: assert property (
        r.st == swc_pkg::SWC_ASLEEP && !ext_rst_s && !r.ctrl.global_irq_enable && wake_req
        |=> !core_ctl.halt)
        else $error("wake blocked by global enable");
    AST_NO_VECTOR: assert property (
        core_ctl.resume && !r.ctrl.global_irq_enable |=> !core_ctl.vector_req)
        else $error("vectored with global enable clear");
    AST_VECTOR_AFTER: assert property (
        core_ctl.resume && r.woke_irq && r.ctrl.global_irq_enable && !ext_rst_s && !wdt_to
        |=> core_ctl.vector_req && core_ctl.vector_addr == swc_pkg::IRQ_VECTOR)
        else $error("no vector after prefetched instruction");
    AST_IMMEDIATE_WAKE: assert property (
        $rose(core_ctl.halt) && wake_req |=> !core_ctl.halt)
        else $error("pending flag did not wake at once");
    AST_WDT_CLEARED: assert property (
        $fell(core_ctl.halt) |=> watchdog_counter == '0)
        else $error("watchdog not cleared on wake");
    AST_OSC_HOLD: assert property (
        core_ctl.halt |-> !core_ctl.osc_enable && core_ctl.io_hold)
        else $error("oscillator or pins not held in sleep");
    AST_WDT_RESET_RUN: assert property (
        r.st == swc_pkg::SWC_RUN && wdt_to && !ext_rst_s |=> core_ctl.dev_reset && !r.timeout_flag_n)
        else $error("watchdog did not reset while running");

    // main scenarios
    COV_IRQ_VECTOR: cover property (core_ctl.resume ##1 core_ctl.vector_req);
    COV_WDT_WAKE: cover property (r.st == swc_pkg::SWC_ASLEEP && wdt_to);
    COV_PIN_RESET_WAKE: cover property (r.st == swc_pkg::SWC_ASLEEP && ext_rst_s);
    COV_FAST_WAKE: cover property ($rose(core_ctl.halt) ##1 $fell(core_ctl.halt));

endmodule

// ===== swc_pkg.sv
// package: constants and types shared by the sleep and wake-up controller
package swc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_FLAGS = 12'h004;
    localparam logic [11:0] ADDR_EVT = 12'h008;
    localparam logic [11:0] ADDR_MASK = 12'h00C;

    // bit positions in the flags word
    localparam int FLG_PD = 0;
    localparam int FLG_TO = 1;
    localparam int FLG_ASLEEP = 2;
    localparam int FLG_EXT = 3;
    localparam int FLG_PC = 4;

    // values after reset
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // timing: watchdog period in microseconds and in cycles
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned WDT_PERIOD_US = 18000;
    localparam int unsigned WDT_CYCLES = WDT_PERIOD_US * CLK_MHZ;
    localparam int WDT_CNT_W = 21;

    // interrupt vector address handed to the core
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // widths of pin and peripheral groups
    localparam int PIN_W = 4;
    localparam int PERIPH_W = 2;
    localparam int SYNC_W = PIN_W + 2;

    ////////////////////////////////////////////////////////////////////////
    // controller states
    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_FETCH_WAIT,
        SWC_ASLEEP,
        SWC_WAKE_EXEC
    } swc_state_t;

    // control register layout
    typedef struct packed {
        logic en_periph;
        logic en_pinchg;
        logic en_ext;
        logic global_irq_enable;
        logic wdt_en;
    } swc_ctrl_t;

    // event and mask register layout
    typedef struct packed {
        logic ext_reset_wake;
        logic wdt_reset;
        logic wdt_wake;
        logic irq_wake;
    } swc_evt_t;

    // requests from the core
    typedef struct packed {
        logic sleep_exec;
        logic clrwdt_exec;
        logic prefetch_valid;
    } swc_core_req_t;

    // controls to the core
    typedef struct packed {
        logic halt;
        logic resume;
        logic vector_req;
        logic [12:0] vector_addr;
        logic dev_reset;
        logic osc_enable;
        logic io_hold;
    } swc_core_ctl_t;

    localparam swc_core_ctl_t CORE_CTL_RESET = '{halt: 1'b0, resume: 1'b0, vector_req: 1'b0,
        vector_addr: IRQ_VECTOR, dev_reset: 1'b0, osc_enable: 1'b1, io_hold: 1'b0};

endpackage

// ===== swc_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/100ps
module swc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // both stages in one state word
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } swc_sync_t;

    swc_sync_t r;
    swc_sync_t next_r;

    // first stage feeds only the second
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;

endmodule

// ===== swc_watchdog.sv
// watchdog counter, counting only while enabled, with clear and time-out pulse
`timescale 1ns/100ps
module swc_watchdog #(
    parameter int unsigned LIMIT = swc_pkg::WDT_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic enable,
    input wire logic clear,
    // status
    output logic [swc_pkg::WDT_CNT_W-1:0] watchdog_counter,
    output logic timeout
);

    // counter and pulse
    typedef struct packed {
        logic [swc_pkg::WDT_CNT_W-1:0] cnt;
        logic to;
    } swc_wdt_t;

    localparam logic [swc_pkg::WDT_CNT_W-1:0] LAST = swc_pkg::WDT_CNT_W'(LIMIT - 1);

    swc_wdt_t r;
    swc_wdt_t next_r;

    // count while enabled, wrap with a pulse
    always_comb begin
        next_r = r;
        next_r.to = 1'b0;
        if (!enable || clear) begin
            next_r.cnt = '0;
        end else if (r.cnt == LAST) begin
            next_r.cnt = '0;
            next_r.to = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign watchdog_counter = r.cnt;
    assign timeout = r.to;

endmodule

// ===== swc_core_model.sv
// behavioural model of the processor core facing the controller
`timescale 1ns/100ps
module swc_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls
    input wire logic go,
    input wire logic slow,
    // requests to the controller
    output swc_pkg::swc_core_req_t core_req
);
    ////////////////////////////////
    logic [1:0] dly; // fetch delay when slow
    // sleep pulse, prefetch now or three cycles later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_req <= '0;
            dly <= 2'h0;
        end else begin
            core_req.sleep_exec <= go;
            core_req.clrwdt_exec <= 1'b0;
            core_req.prefetch_valid <= (go && !slow) || dly == 2'h1;
            dly <= (go && slow) ? 2'h3 : (dly != 2'h0 ? dly - 2'h1 : 2'h0);
        end
    end
endmodule

// ===== test_sleep_wakeup_control.sv
// self-checking testbench for the sleep and wake-up controller
`timescale 1ns/100ps
module test_sleep_wakeup_control;
    ////////////////////////////////
    // stimulus and observed signals
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
    logic ext_reset_pin_n = 1, ext_irq_pin = 0, pready, pslverr, irq, vchk = 0, vexp = 0, rst_d = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [swc_pkg::PIN_W-1:0] gpio = '0;
    logic [swc_pkg::PERIPH_W-1:0] periph = '0;
    logic [1:0] e;
    swc_pkg::swc_core_req_t core_req;
    swc_pkg::swc_core_ctl_t ctl;
    logic [31:0] rd_q[$]; // expected read data
    logic [1:0] wk_q[$]; // expected wakes: b1 reset, b0 vector
    int num_errors = 0, cmp_count = 0, cyc = 0;

    always #5 pclk = ~pclk;

    swc_sleep_wakeup_control #(.WDT_LIMIT(50)) swc_sleep_wakeup_control_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n), .ext_irq_pin(ext_irq_pin),
        .gpio_pins(gpio), .periph_irq_flags(periph), .core_req(core_req), .core_ctl(ctl), .irq(irq));
    swc_core_model swc_core_model_i (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow),
        .core_req(core_req));

    ////////////////////////////////
    // compare tasks
    task automatic chk_reg(string n, logic [31:0] x, logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, x, s);
        end
    endtask
    task automatic chk_ctl(string n, logic x, logic s);
        chk_reg(n, {31'h0, x}, {31'h0, s});
    endtask
    // one apb transfer, held until pready
    task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] x);
        rd_q.push_back(x);
        apb(a, 1'b0, 32'h0);
    endtask
    // sleep request, then wait for halt
    task automatic sleep_op(logic s);
        int n = 0;
        slow <= s;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        do @(posedge pclk); while (ctl.halt !== 1'b1 && ++n < 10);
        chk_ctl("halt", 1'b1, ctl.halt);
    endtask
    task automatic wait_wake;
        int n = 0;
        do @(posedge pclk); while (ctl.halt !== 1'b0 && ++n < 200);
        repeat (3) @(posedge pclk);
    endtask
    task automatic summarize;
        chk_reg("pending", 32'h0, 32'(rd_q.size() + wk_q.size()));
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // monitor: read data and wake kinds against the notes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1)
            chk_ctl("pslverr", paddr > swc_pkg::ADDR_MASK || paddr[1:0] != 2'h0, pslverr);
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk_reg("prdata", rd_q.pop_front(), prdata);
        if (vchk)
            chk_ctl("vector_req", vexp, ctl.vector_req);
        if (vchk && vexp)
            chk_reg("vector_addr", 32'(swc_pkg::IRQ_VECTOR), 32'(ctl.vector_addr));
        vchk = 0;
        rst_d <= ctl.dev_reset;
        if (ctl.resume === 1'b1 || (ctl.dev_reset === 1'b1 && !rst_d)) begin
            e = wk_q.pop_front();
            chk_ctl("dev_reset", e[1], ctl.dev_reset);
            vchk = !e[1];
            vexp = e[0];
        end
    end
    // hang guard
    always @(posedge pclk) begin
        if (++cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end

    ////////////////////////////////
    // test sequence
    initial begin
        void'($urandom(32'hE1FA11A9));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(swc_pkg::ADDR_CTRL, 32'h0);
        rd(swc_pkg::ADDR_FLAGS, 32'h3);
        rd(swc_pkg::ADDR_MASK, 32'h0);
        rd(12'h010, 32'h0);
        $display("test reset done");
        // pin interrupt wake, global enable clear
        r = $urandom();
        apb(swc_pkg::ADDR_CTRL, 1'b1, {r[31:5], 5'h04});
        rd(swc_pkg::ADDR_CTRL, 32'h04);
        sleep_op(1'b0);
        rd(swc_pkg::ADDR_FLAGS, 32'h6);
        chk_ctl("osc_enable", 1'b0, ctl.osc_enable);
        chk_ctl("io_hold", 1'b1, ctl.io_hold);
        wk_q.push_back(2'h0);
        ext_irq_pin <= 1'b1;
        wait_wake();
        ext_irq_pin <= 1'b0;
        rd(swc_pkg::ADDR_FLAGS, 32'hA);
        apb(swc_pkg::ADDR_FLAGS, 1'b1, 32'h8);
        rd(swc_pkg::ADDR_EVT, 32'h1);
        chk_ctl("irq", 1'b0, irq);
        $display("test pin wake done");
        // pending peripheral flag, global enable set, slow fetch
        apb(swc_pkg::ADDR_CTRL, 1'b1, 32'h12);
        r = $urandom();
        periph <= r[1:0] | 2'h1;
        wk_q.push_back(2'h1);
        sleep_op(1'b1);
        wait_wake();
        periph <= '0;
        $display("test pending wake done");
        // watchdog wake with its event unmasked
        apb(swc_pkg::ADDR_EVT, 1'b1, 32'hF);
        apb(swc_pkg::ADDR_MASK, 1'b1, 32'h2);
        apb(swc_pkg::ADDR_CTRL, 1'b1, 32'h01);
        wk_q.push_back(2'h0);
        sleep_op(1'b0);
        wait_wake();
        apb(swc_pkg::ADDR_CTRL, 1'b1, 32'h0);
        rd(swc_pkg::ADDR_FLAGS, 32'h0);
        rd(swc_pkg::ADDR_EVT, 32'h2);
        chk_ctl("irq", 1'b1, irq);
        apb(swc_pkg::ADDR_EVT, 1'b1, 32'h2);
        chk_ctl("irq", 1'b0, irq);
        $display("test watchdog wake done");
        // no source enabled, then reset pin
        sleep_op(1'b0);
        repeat (100) @(posedge pclk);
        chk_ctl("halt", 1'b1, ctl.halt);
        wk_q.push_back(2'h2);
        ext_reset_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        ext_reset_pin_n <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(swc_pkg::ADDR_EVT, 32'h8);
        $display("test reset pin wake done");
        summarize();
    end
endmodule
